// ### include/uffc_pkg.sv
// Purpose: shared constants for the serial frame-format block
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes: control register fields sit in the low byte
package uffc_pkg;
   // register byte offsets
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_TXDATA = 4'h4;
   localparam logic [3:0] OFS_RXDATA = 4'h8;
   localparam logic [3:0] OFS_STATUS = 4'hC;
   localparam logic [3:0] OFS_CLEAR = 4'h0 + 4'h0;
   localparam logic [4:0] OFS_IRQCLR = 5'h10;
   localparam logic [4:0] OFS_IRQEN = 5'h14;
   // control field positions
   localparam int BIT_RXEN = 5;
   localparam int BIT_PSENSE = 4;
   localparam int BIT_PEN = 3;
   localparam int BIT_CLEN = 2;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // status bit positions
   localparam int ST_RXDONE = 0;
   localparam int ST_TXDONE = 1;
   localparam int ST_PARERR = 2;
   localparam int ST_FRMERR = 3;
   localparam int ST_BITS = 4;
   // bit time: system clocks per serial bit by default, near 115200 baud at 50 MHz
   localparam int BAUD_DIV_DEF = 434;
endpackage : uffc_pkg

// ### core/uffc_frame_format.sv
// Purpose: serial port frame-format control with tx/rx framing and parity
// Assumes: 50 MHz sys_clk, synchronous active-high reset, classic wishbone
// Notes: baud rate is a fixed divider parameter; one bit time per enable pulse
// Function
// (R1) parity sense 1: data plus parity hold an even count of ones
// (R2) parity sense 0: data plus parity hold an odd count of ones
// (R3) 8-bit transmit: start, eight data, parity or stop, stop: 11 bits
// (R4) 8-bit receive accepts 10 or 11 bit frames
// (R5) 7-bit transmit: start, seven data, parity or stop, stop: 10 bits
// (R6) 7-bit receive accepts 9 or 10 bit frames
// (R7) 7-bit mode drops bit 7 of the written transmit byte
// (R8) no parity: a second stop bit fills the parity slot
// (R9) parity enable adds and checks parity; disabled omits both
// (R10) receiver enable turns on receiver, its interrupt and receive pin
module uffc_frame_format #(
   parameter int BAUD_DIV = uffc_pkg::BAUD_DIV_DEF
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // serial pins
   input wire logic serial_receive_pin,
   output logic serialTx,
   // interrupt
   output logic irq
);
   localparam int BW = $clog2(BAUD_DIV + 1);

   logic [7:0] ctrl_r;
   logic [7:0] txData_r;
   logic [7:0] rxData_r;
   logic [uffc_pkg::ST_BITS-1:0] status_r;
   logic [uffc_pkg::ST_BITS-1:0] irqEn_r;
   logic ack_r;
   logic [31:0] rdat_r;
   logic txBusy_r;
   logic txStart_r;

   wire rxEnable = ctrl_r[uffc_pkg::BIT_RXEN];
   wire paritySense = ctrl_r[uffc_pkg::BIT_PSENSE];
   wire parityEnable = ctrl_r[uffc_pkg::BIT_PEN];
   wire charLength = ctrl_r[uffc_pkg::BIT_CLEN];

   // bus decode
   wire busReq = wb_cyc_i & wb_stb_i & ~ack_r;
   wire busWr = busReq & wb_we_i & wb_sel_i[0];
   wire selCtrl = wb_adr_i == {1'b0, uffc_pkg::OFS_CTRL};
   wire selTx = wb_adr_i == {1'b0, uffc_pkg::OFS_TXDATA};
   wire selRx = wb_adr_i == {1'b0, uffc_pkg::OFS_RXDATA};
   wire selSt = wb_adr_i == {1'b0, uffc_pkg::OFS_STATUS};
   wire selClr = wb_adr_i == uffc_pkg::OFS_IRQCLR;
   wire selEn = wb_adr_i == uffc_pkg::OFS_IRQEN;
   wire [uffc_pkg::ST_BITS-1:0] clrMask =
      (busWr & selClr) ? wb_dat_i[uffc_pkg::ST_BITS-1:0] : '0;
   wire [31:0] readMux =
      selCtrl ? {24'h000000, ctrl_r} :
      selRx ? {24'h000000, rxData_r} :
      selSt ? {27'h0000000, txBusy_r, status_r} :
      selEn ? {28'h0000000, irqEn_r} : 32'h00000000;

   // bus registers; ack one cycle after the request is seen
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ctrl_r <= uffc_pkg::CTRL_RESET;
         irqEn_r <= '0;
         ack_r <= 1'b0;
         rdat_r <= 32'h00000000;
      end else begin
         ack_r <= busReq;
         if (busReq) rdat_r <= readMux;
         if (busWr & selCtrl) ctrl_r <= wb_dat_i[7:0];
         if (busWr & selEn) irqEn_r <= wb_dat_i[uffc_pkg::ST_BITS-1:0];
      end
   end
   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

   // one bit-time enable; transmitter and receiver do not share the divider phase:
   // each keeps its own counter, so no restart skew between them
   logic [BW-1:0] txDiv_r;
   wire txTick = txDiv_r == BW'(BAUD_DIV - 1);
   always_ff @(posedge sys_clk) begin
      if (reset || !txBusy_r || txTick) txDiv_r <= '0;
      else txDiv_r <= txDiv_r + 1'b1;
   end

   // transmit frame assembly
   wire [7:0] txMasked = charLength ? txData_r : {1'b0, txData_r[6:0]}; // R7
   wire txParity = ^txMasked ^ ~paritySense; // R1 R2
   wire slotBit = parityEnable ? txParity : 1'b1; // R8 R9
   wire [10:0] frame8 = {1'b1, slotBit, txMasked, 1'b0}; // R3
   wire [10:0] frame7 = {1'b1, 1'b1, slotBit, txMasked[6:0], 1'b0}; // R5
   wire [3:0] txLen = charLength ? 4'hB : 4'hA; // R3 R5
   logic [10:0] txShift_r;
   logic [3:0] txCnt_r;
   logic txDoneEv;

   // a write loads the holding byte and starts a frame when idle
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         txData_r <= 8'h00;
         txStart_r <= 1'b0;
      end else begin
         txStart_r <= busWr & selTx & ~txBusy_r;
         if (busWr & selTx & ~txBusy_r) txData_r <= wb_dat_i[7:0];
      end
   end

   // shift out lsb first, one bit per bit time
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         txBusy_r <= 1'b0;
         txShift_r <= 11'h7FF;
         txCnt_r <= 4'h0;
         txDoneEv <= 1'b0;
      end else begin
         txDoneEv <= 1'b0;
         if (txStart_r) begin
            txBusy_r <= 1'b1;
            txShift_r <= charLength ? frame8 : frame7;
            txCnt_r <= txLen;
         end else if (txBusy_r && txTick) begin
            txShift_r <= {1'b1, txShift_r[10:1]};
            txCnt_r <= txCnt_r - 1'b1;
            if (txCnt_r == 4'h1) begin
               txBusy_r <= 1'b0;
               txDoneEv <= 1'b1;
            end
         end
      end
   end
   assign serialTx = txShift_r[0];

   // receive pin synchroniser
   logic rxMeta_r;
   logic rxSync_r;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rxMeta_r <= 1'b1;
         rxSync_r <= 1'b1;
      end else begin
         rxMeta_r <= serial_receive_pin;
         rxSync_r <= rxMeta_r;
      end
   end
   // disabled receiver sees an idle line
   wire rxLine = rxEnable ? rxSync_r : 1'b1; // R10

   // receive: data bits, optional parity, one stop checked
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} uffc_rxst_t;
   uffc_rxst_t rxState_r;
   logic [BW-1:0] rxDiv_r;
   logic [3:0] rxIdx_r;
   logic [8:0] rxShift_r;
   logic rxDoneEv;
   logic parErrEv;
   logic frmErrEv;
   wire rxHalf = rxDiv_r == BW'(BAUD_DIV / 2 - 1);
   wire rxFull = rxDiv_r == BW'(BAUD_DIV - 1);
   // data bits plus parity slot when enabled: 7, 8 or 9
   wire [3:0] rxNeed = 4'h7 + {3'b000, charLength} + {3'b000, parityEnable}; // R4 R6 R9
   wire [7:0] rxData8 = parityEnable ? rxShift_r[7:0] : rxShift_r[8:1];
   wire [7:0] rxData7 = parityEnable ? {1'b0, rxShift_r[8:2]} : {1'b0, rxShift_r[8:2]};
   wire [8:0] rxAligned = charLength ? rxShift_r : {rxShift_r[8:1], 1'b0};
   wire rxParBit = rxShift_r[8];
   wire [7:0] rxWord = charLength ? (parityEnable ? rxAligned[7:0] : rxData8)
                                  : (parityEnable ? {1'b0, rxShift_r[7:1]} : rxData7);
   wire rxParOk = (^rxWord ^ rxParBit) == ~paritySense; // R1 R2

   always_ff @(posedge sys_clk) begin
      if (reset || !rxEnable) begin // R10
         rxState_r <= RX_IDLE;
         rxDiv_r <= '0;
         rxIdx_r <= 4'h0;
         rxShift_r <= 9'h000;
         rxData_r <= 8'h00;
         rxDoneEv <= 1'b0;
         parErrEv <= 1'b0;
         frmErrEv <= 1'b0;
      end else begin
         rxDoneEv <= 1'b0;
         parErrEv <= 1'b0;
         frmErrEv <= 1'b0;
         rxDiv_r <= (rxState_r == RX_IDLE || rxFull || (rxState_r == RX_START && rxHalf))
                    ? '0 : rxDiv_r + 1'b1;
         unique case (rxState_r)
            RX_IDLE: if (!rxLine) rxState_r <= RX_START;
            RX_START: if (rxHalf) begin
               rxState_r <= rxLine ? RX_IDLE : RX_BITS;
               rxIdx_r <= 4'h0;
            end
            RX_BITS: if (rxFull) begin
               rxShift_r <= {rxLine, rxShift_r[8:1]};
               rxIdx_r <= rxIdx_r + 1'b1;
               if (rxIdx_r == rxNeed - 4'h1) rxState_r <= RX_STOP;
            end
            RX_STOP: if (rxFull) begin
               rxState_r <= RX_IDLE;
               rxData_r <= rxWord;
               rxDoneEv <= 1'b1;
               frmErrEv <= ~rxLine;
               parErrEv <= parityEnable & ~rxParOk; // R9
            end
         endcase
      end
   end

   // sticky status: a new event wins over a clear in the same cycle
   wire [uffc_pkg::ST_BITS-1:0] events = {frmErrEv, parErrEv, txDoneEv, rxDoneEv};
   always_ff @(posedge sys_clk) begin
      if (reset) status_r <= '0;
      else status_r <= (status_r & ~clrMask) | events;
   end
   // receive interrupt sources follow the receiver enable
   wire [uffc_pkg::ST_BITS-1:0] irqGate = {rxEnable, rxEnable, 1'b1, rxEnable}; // R10
   assign irq = |(status_r & irqEn_r & irqGate);

   // checks
   tx_length_a: assert property (@(posedge sys_clk) disable iff (reset) // R3 R5
      txStart_r |=> txCnt_r == (charLength ? 4'hB : 4'hA))
      else $error("transmit frame length wrong");
   tx_stopslot_a: assert property (@(posedge sys_clk) disable iff (reset) // R8
      (txStart_r && !parityEnable) |=> txShift_r[txCnt_r - 4'h2] == 1'b1)
      else $error("stop bit missing in parity slot");
   tx_parity_a: assert property (@(posedge sys_clk) disable iff (reset) // R1 R2
      (txStart_r && parityEnable) |=>
         (charLength ? ^txShift_r[9:1] : ^txShift_r[8:1]) == !paritySense)
      else $error("transmit parity sense wrong");
   tx_msb_a: assert property (@(posedge sys_clk) disable iff (reset) // R7
      (txStart_r && !charLength) |=> txShift_r[7:1] == $past(txData_r[6:0]))
      else $error("bit 7 leaked in seven bit mode");
   rx_off_a: assert property (@(posedge sys_clk) disable iff (reset) // R10
      !rxEnable |=> rxState_r == RX_IDLE && !rxDoneEv)
      else $error("receiver active while disabled");
   rx_parity_a: assert property (@(posedge sys_clk) disable iff (reset) // R9
      !parityEnable |-> !parErrEv)
      else $error("parity error without parity");
   rx_len_a: assert property (@(posedge sys_clk) disable iff (reset) // R4 R6
      (rxState_r == RX_BITS && rxFull && rxIdx_r == rxNeed - 4'h1) |=> rxState_r == RX_STOP)
      else $error("receive data length wrong");
   tx_start_a: assert property (@(posedge sys_clk) disable iff (reset) // R3
      txStart_r |=> !serialTx && txBusy_r)
      else $error("start bit not driven");

   // the bus answer is a single pulse
   ack_pulse_a: assert property (@(posedge sys_clk) disable iff (reset)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");

   // a fresh request is answered in the next cycle
   ack_follow_a: assert property (@(posedge sys_clk) disable iff (reset)
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("request not answered");

   // a control write lands in the register
   ctrl_write_a: assert property (@(posedge sys_clk) disable iff (reset)
      (busWr && selCtrl) |=> ctrl_r == $past(wb_dat_i[7:0]))
      else $error("control write lost");

   // line rests high between frames
   tx_idle_a: assert property (@(posedge sys_clk) disable iff (reset) // R3 R5
      (!txBusy_r && !txStart_r) |-> serialTx)
      else $error("transmit line not idle");

   // top shift slot of every frame is high; it is the last stop bit only in 8-bit frames
   tx_stop_a: assert property (@(posedge sys_clk) disable iff (reset) // R3 R5
      txStart_r |=> txShift_r[10] == 1'b1)
      else $error("final stop bit missing");

   // bit counter stays inside the frame length
   tx_cnt_a: assert property (@(posedge sys_clk) disable iff (reset) // R3 R5
      txBusy_r |-> txCnt_r != 4'h0 && txCnt_r <= 4'hB)
      else $error("transmit counter out of range");

   // each bit holds for a whole bit time
   tx_hold_a: assert property (@(posedge sys_clk) disable iff (reset) // R3 R5
      (txBusy_r && !txTick && !txStart_r) |=> $stable(txShift_r))
      else $error("transmit bit changed early");

   // done pulse only once the frame is out
   tx_done_a: assert property (@(posedge sys_clk) disable iff (reset)
      txDoneEv |-> !txBusy_r)
      else $error("done while still busy");

   // a glitch shorter than half a bit is no start
   rx_start_a: assert property (@(posedge sys_clk) disable iff (reset)
      (rxState_r == RX_START && rxHalf && rxLine) |=> rxState_r == RX_IDLE)
      else $error("false start accepted");

   // the index never runs past the data and parity slots
   rx_idx_a: assert property (@(posedge sys_clk) disable iff (reset) // R4 R6
      rxState_r == RX_BITS |-> rxIdx_r < rxNeed)
      else $error("receive index overrun");

   // a character is only delivered from the stop slot
   rx_done_a: assert property (@(posedge sys_clk) disable iff (reset) // R4 R6
      rxDoneEv |-> $past(rxState_r) == RX_STOP)
      else $error("receive done out of place");

   // seven bit characters read back with the top bit clear
   rx_sample7_a: assert property (@(posedge sys_clk) disable iff (reset) // R6
      (rxState_r == RX_STOP && rxFull && !charLength) |=> !rxData_r[7])
      else $error("bit 7 set in seven bit mode");

   // good parity raises no error
   rx_parok_a: assert property (@(posedge sys_clk) disable iff (reset) // R1 R2
      (rxState_r == RX_STOP && rxFull && parityEnable && rxParOk) |=> !parErrEv)
      else $error("false parity error");

   // bad parity is always flagged
   rx_parbad_a: assert property (@(posedge sys_clk) disable iff (reset) // R1 R2 R9
      (rxState_r == RX_STOP && rxFull && parityEnable && !rxParOk) |=> parErrEv)
      else $error("parity error missed");

   // a high stop sample is no framing error
   rx_frm_a: assert property (@(posedge sys_clk) disable iff (reset)
      (rxState_r == RX_STOP && rxFull && rxLine) |=> !frmErrEv)
      else $error("false framing error");

   // a disabled receiver sees only idle
   rx_line_a: assert property (@(posedge sys_clk) disable iff (reset) // R10
      !rxEnable |-> rxLine)
      else $error("receive pin not gated");

   // events always reach the status register
   status_set_a: assert property (@(posedge sys_clk) disable iff (reset)
      |events |=> (status_r & $past(events)) == $past(events))
      else $error("status event lost");

   // with the receiver off only transmit done may interrupt
   irq_gate_a: assert property (@(posedge sys_clk) disable iff (reset) // R10
      (!rxEnable && !(status_r[uffc_pkg::ST_TXDONE] && irqEn_r[uffc_pkg::ST_TXDONE])) |-> !irq)
      else $error("receive interrupt while disabled");
endmodule : uffc_frame_format

// ### bench/uffc_remote.sv
// Purpose: remote serial partner for the frame-format block
// Assumes: idle-high line, lsb first, BIT sys_clk cycles per bit
// Notes: a frame on lineIn is caught only if it starts after the previous capture ends; send drives one frame
module uffc_remote #(
   parameter int BIT = 8
) (
   // clock
   input wire logic sys_clk,
   // serial lines
   input wire logic lineIn,
   output logic lineOut
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [10:0] lastFrame = 11'h7FF;
   int frameCount = 0;
   initial lineOut = 1'b1;
   // sample mid-bit; eleven slots, so a short frame shows idle in the last
   always begin
      @(negedge lineIn);
      repeat (BIT / 2) @(posedge sys_clk);
      for (int i = 0; i < 11; i++) begin
         lastFrame[i] = lineIn;
         repeat (BIT) @(posedge sys_clk);
      end
      frameCount++;
   end
   // drive bits just after an edge; the line returns to idle high after
   task automatic send(input logic [10:0] frame, input int n);
      for (int i = 0; i < n; i++) begin
         lineOut <= frame[i];
         repeat (BIT) @(posedge sys_clk);
      end
      lineOut <= 1'b1;
   endtask : send
endmodule : uffc_remote

// ### bench/uart_frame_format_control_tb_top.sv
// Purpose: self-checking bench for the frame-format block
// Assumes: BAUD_DIV shortened to 8 so frames stay short
// Notes: wishbone byte lane 0 carries all register data
module uart_frame_format_control_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BIT = 8;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic wbCyc = 1'b0;
   logic wbStb = 1'b0;
   logic wbWe = 1'b0;
   logic [4:0] wbAdr = 5'h00;
   logic [31:0] wbDat = 32'h0;
   logic [31:0] wbDatO;
   logic wbAck, rxLine, txLine, irq;
   logic [31:0] rd;
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;
   uffc_frame_format #(.BAUD_DIV(BIT)) i_dut (.sys_clk(sys_clk), .reset(reset),
      .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
      .wb_sel_i(4'hF), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
      .serial_receive_pin(rxLine), .serialTx(txLine), .irq(irq));
   uffc_remote #(.BIT(BIT)) u_remote (.sys_clk(sys_clk), .lineIn(txLine), .lineOut(rxLine));
   // 50 MHz clock
   initial begin
      forever #10 sys_clk = ~sys_clk;
   end
   // hang guard: far above the thousand or so cycles the tests need
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // classic cycle: hold everything until ack is sampled, then one idle cycle
   task automatic wb_cycle(input logic we, input logic [4:0] a, input logic [31:0] d);
      int k;
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbDat <= d;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (wbAck !== 1'b1 && k < 100);
      if (k >= 100) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      end
      rd = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      @(posedge sys_clk);
   endtask : wb_cycle
   // expected frame: start, data lsb first, slot, stop, then idle in 7-bit frames only
   function automatic logic [10:0] frame_of(input logic [7:0] ctl, input logic [7:0] d);
      logic [7:0] v;
      logic par;
      v = ctl[2] ? d : {1'b0, d[6:0]};
      par = ctl[4] ? ^v : ~^v;
      frame_of = {3'h7, v[7:0]} << 1;
      frame_of[10] = 1'b1;
      frame_of[ctl[2] ? 9 : 8] = ctl[3] ? par : 1'b1;
   endfunction : frame_of
   task automatic tx_case(input logic [7:0] ctl);
      int c;
      c = u_remote.frameCount;
      wb_cycle(1'b1, 5'h00, {24'h0, ctl});
      wb_cycle(1'b1, 5'h04, 32'h0000_00B5);
      for (int k = 0; k < 300 && u_remote.frameCount == c; k++) @(posedge sys_clk);
      check({21'h0, u_remote.lastFrame}, {21'h0, frame_of(ctl, 8'hB5)});
      repeat (BIT) @(posedge sys_clk);
   endtask : tx_case
   // flip corrupts the frame; status is checked on rx done and parity error
   task automatic rx_case(input logic [7:0] ctl, input logic [7:0] d, input int n,
                          input logic [10:0] flip, input logic [7:0] expD, input logic [31:0] st);
      wb_cycle(1'b1, 5'h10, 32'h0000_000F);
      wb_cycle(1'b1, 5'h00, {24'h0, ctl});
      u_remote.send(frame_of(ctl, d) ^ flip, n);
      repeat (BIT) @(posedge sys_clk);
      wb_cycle(1'b0, 5'h0C, 32'h0);
      check(rd & 32'h5, st);
      wb_cycle(1'b0, 5'h08, 32'h0);
      if (st[0]) check(rd, {24'h0, expD});
   endtask : rx_case
   // main sequence
   initial begin
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      wb_cycle(1'b0, 5'h1C, 32'h0);
      check(rd, 32'h0);
      tx_case(8'h04);
      tx_case(8'h0C);
      tx_case(8'h1C);
      tx_case(8'h00);
      tx_case(8'h08);
      tx_case(8'h18);
      wb_cycle(1'b1, 5'h14, 32'h0000_0001);
      rx_case(8'h3C, 8'h5A, 11, 11'h000, 8'h5A, 32'h1);
      check({31'h0, irq}, 32'h1);
      wb_cycle(1'b1, 5'h10, 32'h0000_000F);
      check({31'h0, irq}, 32'h0);
      rx_case(8'h2C, 8'h5A, 11, 11'h200, 8'h5A, 32'h5);
      rx_case(8'h20, 8'hD3, 9, 11'h000, 8'h53, 32'h1);
      rx_case(8'h24, 8'hD3, 10, 11'h000, 8'hD3, 32'h1);
      rx_case(8'h1C, 8'h5A, 11, 11'h000, 8'h5A, 32'h0);
      check({31'h0, irq}, 32'h0);
      complete_run();
   end
endmodule : uart_frame_format_control_tb_top
